// >>> design/swf_top.sv
// Purpose: Execution block for subtract_wreg_from_file with an AHB-Lite
//          register port and a flip-flop data memory.
// Assumes: Single word transfers only; one master; hready from this slave.
// Notes:   Writing the operation register executes the instruction.
//          Data memory smaller than the 12-bit space aliases across banks.
//          Transfer size is not checked; every access is a whole word.
//
// Contract
// - Result is addressed byte minus working register, two's complement, 8 bits.
// - Destination bit 0 writes working register; addressed byte stays unchanged.
// - Destination bit 1, the default, writes result back to addressed byte.
// - Access bit 0 resolves the address inside the fixed access bank.
// - Access bit 1, the default, uses the bank select register for the bank.
// - Extended set with access bit 0 indexes addresses up to 5Fh.
//
// Our own choices: register access over AHB-Lite and the register offsets.

`timescale 1ns/1ns
`default_nettype none

module swf_top #(
  parameter int DEPTH = 256
) (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire logic                      hsel,
  input  wire logic             [31:0]   haddr,
  input  wire logic             [1:0]    htrans,
  input  wire logic                      hwrite,
  input  wire logic             [2:0]    hsize,
  input  wire logic             [31:0]   hwdata,
  input  wire logic                      hready,
  output var  logic                      hreadyout,
  output var  logic             [31:0]   hrdata,
  output var  logic                      hresp,
  output var  logic             [7:0]    wreg_value,
  output var  swf_pkg::swf_flags_s       flags_value,
  output var  logic                      op_done
);

  localparam int IW = $clog2(DEPTH);

  // ==========================================================================
  // State
  // All state lives in one packed struct; the memory rides along in it
  typedef struct packed {
    swf_pkg::swf_bus_e    bus;
    logic                 wr_pend;
    logic [31:0]          wr_addr;
    logic [31:0]          rd_addr;
    logic                 hreadyout;
    logic [31:0]          hrdata;
    logic                 hresp;
    swf_pkg::swf_op_s     op;
    logic [7:0]           wreg;
    logic [3:0]           bank;
    swf_pkg::swf_flags_s  flags;
    logic                 ext_en;
    logic [11:0]          index_base;
    logic [11:0]          last_addr;
    logic                 last_indexed;
    logic                 done;
    logic [DEPTH-1:0][7:0] mem;
  } swf_state_s;

  swf_state_s           st_r;
  swf_state_s           st_nxt;

  logic                 accept;
  logic                 exec;
  swf_pkg::swf_op_s     op_now;
  logic [11:0]          res_addr;
  logic                 res_indexed;
  logic [IW-1:0]        res_idx;
  logic [7:0]           alu_result;
  swf_pkg::swf_flags_s  alu_flags;

  // ==========================================================================
  // Decode helpers
  // Misaligned or out-of-range addresses fall through and read as zero
  function automatic logic is_mem(input logic [31:0] a);
    logic [31:0] top;
    top = swf_pkg::OFS_MEM_BASE + 32'(DEPTH * 4);
    is_mem = (a >= swf_pkg::OFS_MEM_BASE) && (a < top) && (a[1:0] == 2'h0);
  endfunction

  // Word index into the data memory; is_mem has already vetted the range
  function automatic logic [IW-1:0] mem_idx(input logic [31:0] a);
    logic [31:0] off;
    off = a - swf_pkg::OFS_MEM_BASE;
    mem_idx = off[IW+1:2];
  endfunction

  // Reads are served from registered state one cycle after the address
  // phase, which is what lets a write just ahead of a read show up in it
  function automatic logic [31:0] read_word(input swf_state_s s,
                                            input logic [31:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == swf_pkg::OFS_OPERATION)
    begin
      w[9:0] = s.op;
    end
    else if (a == swf_pkg::OFS_WREG)
    begin
      w[7:0] = s.wreg;
    end
    else if (a == swf_pkg::OFS_BANK)
    begin
      w[3:0] = s.bank;
    end
    else if (a == swf_pkg::OFS_STATUS)
    begin
      w[4:0] = s.flags;
    end
    else if (a == swf_pkg::OFS_CONFIG)
    begin
      w[swf_pkg::CFG_EXT_BIT] = s.ext_en;
    end
    else if (a == swf_pkg::OFS_INDEX_BASE)
    begin
      w[11:0] = s.index_base;
    end
    else if (a == swf_pkg::OFS_LAST_ADDR)
    begin
      w[11:0] = s.last_addr;
      w[swf_pkg::LAST_IDX_BIT] = s.last_indexed;
    end
    else if (is_mem(a))
    begin
      w[7:0] = s.mem[mem_idx(a)];
    end
    read_word = w;
  endfunction

  // Register side of a write data phase; an operation write also fires
  // the instruction, which is handled with the rest of the next state
  function automatic swf_state_s write_word(input swf_state_s s,
                                            input logic [31:0] a,
                                            input logic [31:0] d);
    swf_state_s n;
    n = s;
    if (a == swf_pkg::OFS_OPERATION)
    begin
      n.op = swf_pkg::swf_op_s'(d[9:0]);
    end
    else if (a == swf_pkg::OFS_WREG)
    begin
      n.wreg = d[7:0];
    end
    else if (a == swf_pkg::OFS_BANK)
    begin
      n.bank = d[3:0];
    end
    else if (a == swf_pkg::OFS_STATUS)
    begin
      n.flags = swf_pkg::swf_flags_s'(d[4:0]);
    end
    else if (a == swf_pkg::OFS_CONFIG)
    begin
      n.ext_en = d[swf_pkg::CFG_EXT_BIT];
    end
    else if (a == swf_pkg::OFS_INDEX_BASE)
    begin
      n.index_base = d[11:0];
    end
    else if (is_mem(a))
    begin
      n.mem[mem_idx(a)] = d[7:0];
    end
    write_word = n;
  endfunction

  // ==========================================================================
  // Operand path
  // The operation word is taken straight from hwdata so the instruction
  // completes at the same edge that ends the bus write.
  assign exec   = st_r.wr_pend && (st_r.wr_addr == swf_pkg::OFS_OPERATION);
  assign op_now = exec ? swf_pkg::swf_op_s'(hwdata[9:0]) : st_r.op;
  assign accept = hsel && hready && (htrans == swf_pkg::HTRANS_NONSEQ);

  // Resolves bank, access bank or indexed address for the operand
  swf_addr u_addr (
    .bank       (st_r.bank),
    .ext_en     (st_r.ext_en),
    .index_base (st_r.index_base),
    .op         (op_now),
    .addr       (res_addr),
    .indexed    (res_indexed)
  );

  // Memory smaller than the 12-bit space aliases on the low address bits
  assign res_idx = res_addr[IW-1:0];

  // Result and flags are combinational; the state register keeps them
  swf_alu u_alu (
    .file_byte (st_r.mem[res_idx]),
    .wreg_byte (st_r.wreg),
    .result    (alu_result),
    .flags     (alu_flags)
  );

  // ==========================================================================
  // Next state
  always_comb
  begin
    // Pulses and the bus handshake drop back each cycle unless set below
    st_nxt           = st_r;
    st_nxt.done      = 1'b0;
    st_nxt.wr_pend   = 1'b0;
    st_nxt.hreadyout = 1'b1;
    st_nxt.hresp     = swf_pkg::HRESP_OKAY;

    // Register writes in their data phase
    if (st_r.wr_pend)
    begin
      st_nxt = write_word(st_nxt, st_r.wr_addr, hwdata);
    end

    // Instruction execution, one cycle
    // Runs after the register writes; only an operation write triggers it
    if (exec)
    begin
      st_nxt.flags        = alu_flags;
      st_nxt.last_addr    = res_addr;
      st_nxt.last_indexed = res_indexed;
      st_nxt.done         = 1'b1;
      if (op_now.d)
      begin
        st_nxt.mem[res_idx] = alu_result;
      end
      else
      begin
        st_nxt.wreg = alu_result;
      end
    end

    // Bus sequencing
    case (st_r.bus)
      swf_pkg::SWF_BUS_IDLE:
      begin
        if (accept && hwrite)
        begin
          st_nxt.wr_pend = 1'b1;
          st_nxt.wr_addr = haddr;
        end
        else if (accept)
        begin
          // One wait state lets a write just before this read land first
          st_nxt.rd_addr   = haddr;
          st_nxt.hreadyout = 1'b0;
          st_nxt.bus       = swf_pkg::SWF_BUS_RWAIT;
        end
      end
      swf_pkg::SWF_BUS_RWAIT:
      begin
        // Answer stands in the next cycle as hreadyout returns high
        st_nxt.hrdata = read_word(st_r, st_r.rd_addr);
        st_nxt.bus    = swf_pkg::SWF_BUS_IDLE;
      end
      default:
      begin
        st_nxt.bus = swf_pkg::SWF_BUS_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // Memory and the last-address record clear through the whole-struct reset
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r            <= '0;
      st_r.bus        <= swf_pkg::SWF_BUS_IDLE;
      st_r.hreadyout  <= 1'b1;
      st_r.hresp      <= swf_pkg::HRESP_OKAY;
      st_r.op         <= swf_pkg::RST_OP;
      st_r.wreg       <= swf_pkg::RST_WREG;
      st_r.bank       <= swf_pkg::RST_BANK;
      st_r.flags      <= swf_pkg::RST_FLAGS;
      st_r.ext_en     <= swf_pkg::RST_EXT;
      st_r.index_base <= swf_pkg::RST_INDEX;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // Every port is a direct view of a register, never of logic
  assign hreadyout   = st_r.hreadyout;
  assign hrdata      = st_r.hrdata;
  assign hresp       = st_r.hresp;
  assign wreg_value  = st_r.wreg;
  assign flags_value = st_r.flags;
  assign op_done     = st_r.done;

endmodule // swf_top

`default_nettype wire

// >>> design/swf_pkg.sv
// Purpose: Shared constants and types for the subtract-working-register-
//          from-file execution block.
// Assumes: 32-bit AHB-Lite register bus, one word per register.
// Notes:   Status flag layout and operation word layout follow the
//          packed structs below.

package swf_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [31:0] OFS_OPERATION  = 32'h0000_0000;
  localparam logic [31:0] OFS_WREG       = 32'h0000_0004;
  localparam logic [31:0] OFS_BANK       = 32'h0000_0008;
  localparam logic [31:0] OFS_STATUS     = 32'h0000_000C;
  localparam logic [31:0] OFS_CONFIG     = 32'h0000_0010;
  localparam logic [31:0] OFS_INDEX_BASE = 32'h0000_0014;
  localparam logic [31:0] OFS_LAST_ADDR  = 32'h0000_0018;
  localparam logic [31:0] OFS_MEM_BASE   = 32'h0000_0400;

  // ==========================================================================
  // Field positions
  localparam int OP_F_LSB      = 0;
  localparam int OP_D_BIT      = 8;
  localparam int OP_A_BIT      = 9;
  localparam int ST_C_BIT      = 0;
  localparam int ST_DC_BIT     = 1;
  localparam int ST_Z_BIT      = 2;
  localparam int ST_OV_BIT     = 3;
  localparam int ST_N_BIT      = 4;
  localparam int CFG_EXT_BIT   = 0;
  localparam int LAST_IDX_BIT  = 16;

  // ==========================================================================
  // Access bank layout
  localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_LOW_PAGE  = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hF;

  // ==========================================================================
  // Bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } swf_flags_s;

  typedef struct packed {
    logic       a;
    logic       d;
    logic [7:0] f;
  } swf_op_s;

  typedef enum logic [1:0] {
    SWF_BUS_IDLE  = 2'h1,
    SWF_BUS_RWAIT = 2'h2
  } swf_bus_e;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  RST_WREG  = 8'h00;
  localparam logic [3:0]  RST_BANK  = 4'h0;
  localparam swf_flags_s  RST_FLAGS = 5'h00;
  localparam logic        RST_EXT   = 1'b0;
  localparam logic [11:0] RST_INDEX = 12'h000;
  localparam swf_op_s     RST_OP    = 10'h300;

endpackage

// >>> design/swf_alu.sv
// Purpose: Byte subtractor, file minus working register, with flags.
// Assumes: Purely combinational; caller registers the outputs.
// Notes:   Borrow is reported as inverted carry.

`timescale 1ns/1ns
`default_nettype none

module swf_alu (
  input  wire logic [7:0]         file_byte,
  input  wire logic [7:0]         wreg_byte,
  output var  logic [7:0]         result,
  output var  swf_pkg::swf_flags_s flags
);

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // ==========================================================================
  // Two's complement subtract as add of inverted operand plus one
  always_comb
  begin
    full_sum = {1'b0, file_byte} + {1'b0, ~wreg_byte} + 9'h001;
    low_sum  = {1'b0, file_byte[3:0]} + {1'b0, ~wreg_byte[3:0]} + 5'h01;
    result   = full_sum[7:0];
    flags.c  = full_sum[8];
    flags.dc = low_sum[4];
    flags.z  = (full_sum[7:0] == 8'h00);
    flags.n  = full_sum[7];
    // Overflow only when operand signs differ and result sign leaves file's
    flags.ov = (file_byte[7] ^ wreg_byte[7]) & (file_byte[7] ^ full_sum[7]);
  end

endmodule // swf_alu

`default_nettype wire

// >>> design/swf_addr.sv
// Purpose: Resolve the 8-bit operand field into a 12-bit data address.
// Assumes: Combinational; bank and index base come from registers.
// Notes:   Access bank offsets above 5Fh map onto the top page.

`timescale 1ns/1ns
`default_nettype none

module swf_addr (
  input  wire logic             [3:0]  bank,
  input  wire logic                    ext_en,
  input  wire logic             [11:0] index_base,
  input  wire swf_pkg::swf_op_s        op,
  output var  logic             [11:0] addr,
  output var  logic                    indexed
);

  // ==========================================================================
  // Address resolution
  always_comb
  begin
    indexed = 1'b0;
    if (op.a)
    begin
      addr = {bank, op.f};
    end
    else if (ext_en && (op.f <= swf_pkg::ACCESS_LOW_LIMIT))
    begin
      // Wraps within the 12-bit data space by design
      addr    = index_base + {4'h0, op.f};
      indexed = 1'b1;
    end
    else if (op.f <= swf_pkg::ACCESS_LOW_LIMIT)
    begin
      addr = {swf_pkg::ACCESS_LOW_PAGE, op.f};
    end
    else
    begin
      addr = {swf_pkg::ACCESS_HIGH_PAGE, op.f};
    end
  end

endmodule // swf_addr

`default_nettype wire

// >>> testbench/swf_monitor.sv
// Purpose: Port checks for swf_top.
// Assumes: hready is tied to hreadyout.
// Notes:   Memory results are judged by the bench.
`timescale 1ns/1ns
`default_nettype none
module swf_monitor #(
  parameter int DEPTH = 256
) (
  input wire logic                core_clk,
  input wire logic                nrst,
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic [7:0]          wreg_value,
  input wire swf_pkg::swf_flags_s flags_value,
  input wire logic                op_done
);
  // ==========================================
  // Data phase tracking
  logic        wr_r;
  logic [31:0] adr_r;
  logic        acc;
  logic        op_end;
  logic        w_end;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_r  <= 1'b0;
      adr_r <= 32'h0000_0000;
    end
    else if (hready)
    begin
      wr_r  <= acc && hwrite;
      adr_r <= haddr;
    end
  end
  assign acc = hsel && hready && htrans == swf_pkg::HTRANS_NONSEQ;
  assign op_end = wr_r && hready && adr_r == swf_pkg::OFS_OPERATION;
  assign w_end = op_end || (wr_r && hready && adr_r == swf_pkg::OFS_WREG);
  // ==========================================
  // Properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  a_resp_okay: assert property (hresp == swf_pkg::HRESP_OKAY)
    else $error("response not okay");
  a_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (acc && hwrite |=> hreadyout)
    else $error("write stalled");
  a_op_pulse: assert property (op_end |=> op_done)
    else $error("no done after operation");
  a_done_cause: assert property (op_done |-> $past(op_end))
    else $error("done without operation");
  a_wreg_keep: assert property (
    op_done && $past(hwdata[8]) |-> $stable(wreg_value))
    else $error("working register moved");
  a_wreg_cause: assert property ($changed(wreg_value) |-> $past(w_end))
    else $error("working register changed unasked");
  a_zero_flag: assert property (
    op_done && !$past(hwdata[8]) |-> flags_value.z == (wreg_value == 8'h00))
    else $error("zero flag wrong");
  a_neg_flag: assert property (
    op_done && !$past(hwdata[8]) |-> flags_value.n == wreg_value[7])
    else $error("negative flag wrong");
endmodule // swf_monitor
bind swf_top swf_monitor #(.DEPTH(DEPTH)) mon_u (
  .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .wreg_value(wreg_value),
  .flags_value(flags_value), .op_done(op_done));
`default_nettype wire

// >>> testbench/swf_host.sv
// Purpose: Bus master standing in for the decoder side.
// Assumes: Single word transfers, one slave.
// Notes:   Released lines are scrambled, not held.
`timescale 1ns/1ns
`default_nettype none
module swf_host (
  input  wire logic        core_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= swf_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hwdata <= ~hwdata;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= w ? wd : ~hwdata;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule // swf_host
`default_nettype wire

// >>> testbench/subtract_w_from_file_tb.sv
// Purpose: Self-checking bench for swf_top.
// Assumes: hready looped back from hreadyout.
// Notes:   Expected flags are recomputed here.
`timescale 1ns/1ns
`default_nettype none
module subtract_w_from_file_tb;
  localparam logic [55:0] FV = 56'h03_02_01_80_10_7F_00;
  localparam logic [55:0] WV = 56'h02_02_02_01_01_FF_01;
  logic                core_clk;
  logic                nrst;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic                hreadyout;
  logic [31:0]         hrdata;
  logic                hresp;
  logic [7:0]          wreg_value;
  swf_pkg::swf_flags_s flags_value;
  logic                op_done;
  int                  n_fail;
  int                  comparisons;
  swf_top #(.DEPTH(256)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .wreg_value(wreg_value), .flags_value(flags_value),
    .op_done(op_done));
  swf_host host_u (
    .core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
  // ==========================================
  // Tasks
  task automatic wrap_up();
    $display("mismatches %0d of %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    host_u.xfer(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    host_u.xfer(1'b0, a, 32'h0000_0000, x);
    chk(x, e);
  endtask
  task automatic run_sub(input int i);
    logic [7:0]  f;
    logic [7:0]  w;
    logic [7:0]  r;
    logic [7:0]  fa;
    logic [4:0]  fl;
    logic [31:0] ma;
    f = FV[8*i +: 8];
    w = WV[8*i +: 8];
    r = f - w;
    fa = 8'h20 + 8'(i);
    ma = swf_pkg::OFS_MEM_BASE + {22'h0, fa, 2'h0};
    fl = {r[7], (f[7] ^ w[7]) & (r[7] ^ f[7]), r == 8'h00,
          f[3:0] >= w[3:0], f >= w};
    wr(swf_pkg::OFS_BANK, {28'h0, i[3:0]});
    wr(ma, {24'h0, f});
    wr(swf_pkg::OFS_WREG, {24'h0, w});
    wr(swf_pkg::OFS_OPERATION, {22'h0, 1'b1, i[0], fa});
    // Let the executing edge land before looking
    @(negedge core_clk);
    chk({27'h0, flags_value}, {27'h0, fl});
    chk({24'h0, wreg_value}, {24'h0, (i[0] ? w : r)});
    rdc(swf_pkg::OFS_STATUS, {27'h0, fl});
    rdc(swf_pkg::OFS_LAST_ADDR, {20'h0, i[3:0], fa});
    rdc(ma, {24'h0, (i[0] ? r : f)});
  endtask
  task automatic run_adr(input logic x, input logic [9:0] op,
                         input logic [31:0] e);
    wr(swf_pkg::OFS_CONFIG, {31'h0, x});
    wr(swf_pkg::OFS_OPERATION, {22'h0, op});
    rdc(swf_pkg::OFS_LAST_ADDR, e);
  endtask
  // ==========================================
  // Sequence
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial
  begin
    #200000;
    n_fail++;
    wrap_up();
  end
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    nrst = 1'b0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    rdc(swf_pkg::OFS_OPERATION, 32'h0000_0300);
    rdc(swf_pkg::OFS_STATUS, 32'h0000_0000);
    rdc(32'h0000_0200, 32'h0000_0000);
    for (int i = 0; i < 7; i++)
      run_sub(i);
    rdc(swf_pkg::OFS_WREG, 32'h0000_0001);
    wr(swf_pkg::OFS_BANK, 32'h0000_0005);
    wr(swf_pkg::OFS_INDEX_BASE, 32'h0000_0123);
    run_adr(1'b0, 10'h010, 32'h0000_0010);
    run_adr(1'b0, 10'h0A0, 32'h0000_0FA0);
    run_adr(1'b1, 10'h005, 32'h0001_0128);
    run_adr(1'b1, 10'h05F, 32'h0001_0182);
    run_adr(1'b1, 10'h060, 32'h0000_0F60);
    run_adr(1'b1, 10'h205, 32'h0000_0505);
    rdc(swf_pkg::OFS_BANK, 32'h0000_0005);
    rdc(swf_pkg::OFS_INDEX_BASE, 32'h0000_0123);
    rdc(swf_pkg::OFS_CONFIG, 32'h0000_0001);
    rdc(swf_pkg::OFS_OPERATION, 32'h0000_0205);
    wr(swf_pkg::OFS_STATUS, 32'h0000_0015);
    rdc(swf_pkg::OFS_STATUS, 32'h0000_0015);
    wrap_up();
  end
endmodule // subtract_w_from_file_tb
`default_nettype wire
